// ### common/ilu_pkg.sv
package ilu_pkg;

    // Datapath widths
    localparam int ILU_XLEN       = 32;
    localparam int ILU_DISP_W     = 16;
    localparam int ILU_REG_IDX_W  = 5;
    localparam int ILU_BYTE_W     = 8;
    localparam int ILU_HALF_W     = 16;
    localparam int ILU_REG_COUNT  = 32;

    // Reset values
    localparam logic [31:0] ILU_RST_WORD = 32'h0000_0000;
    localparam logic [4:0]  ILU_RST_IDX  = 5'h00;
    localparam logic [4:0]  ILU_REG_ZERO = 5'h00;

    // Operand sizes
    typedef enum logic [1:0] {
        ILU_SZ_BYTE = 2'b00,
        ILU_SZ_HALF = 2'b01,
        ILU_SZ_WORD = 2'b10
    } ilu_size_t;

    // Addressing modes
    typedef enum logic [0:0] {
        ILU_AM_DISP  = 1'b0,
        ILU_AM_INDEX = 1'b1
    } ilu_amode_t;

    // Decoded load issued by the pipeline
    typedef struct packed {
        ilu_size_t   size;
        logic        algebraic;
        logic        update;
        ilu_amode_t  amode;
        logic [4:0]  dest;
        logic [4:0]  base;
        logic [4:0]  index;
        logic [15:0] disp;
    } ilu_op_t;

    // Register write port
    typedef struct packed {
        logic        en;
        logic [4:0]  idx;
        logic [31:0] data;
    } ilu_wr_t;

endpackage : ilu_pkg

// ### core/ilu_regfile.sv
`timescale 1ns/1ps

module ilu_regfile
    import ilu_pkg::*;
#(
    parameter int DEPTH = ILU_REG_COUNT,
    parameter int WIDTH = ILU_XLEN
) (
    // Clock and reset
    input  wire logic                     clock_in,
    input  wire logic                     rst_n_in,
    // Write ports, port b wins on a clash
    input  wire logic                     wa_en_in,
    input  wire logic [$clog2(DEPTH)-1:0] wa_idx_in,
    input  wire logic [WIDTH-1:0]         wa_data_in,
    input  wire logic                     wb_en_in,
    input  wire logic [$clog2(DEPTH)-1:0] wb_idx_in,
    input  wire logic [WIDTH-1:0]         wb_data_in,
    // Registered read ports
    input  wire logic [$clog2(DEPTH)-1:0] ra_idx_in,
    input  wire logic [$clog2(DEPTH)-1:0] rb_idx_in,
    output logic      [WIDTH-1:0]         ra_data_out,
    output logic      [WIDTH-1:0]         rb_data_out
);

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("ilu_regfile: bad geometry");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // Storage; reset clears every register
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            if (wa_en_in) begin
                mem[wa_idx_in] <= wa_data_in;
            end
            if (wb_en_in) begin
                mem[wb_idx_in] <= wb_data_in;
            end
        end
    end

    // Read data from a register, one cycle after the index
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ra_data_out <= '0;
            rb_data_out <= '0;
        end else begin
            ra_data_out <= mem[ra_idx_in];
            rb_data_out <= mem[rb_idx_in];
        end
    end

endmodule : ilu_regfile

// ### core/ilu_load_unit.sv
`timescale 1ns/1ps

// Operation
// - Zero-extending narrow loads clear all unused upper destination bits.
// - Algebraic loads fill unused upper bits with the operand sign bit.
// - Invalid update loads give bounded undefined result, no exception.
// - Byte zero loads fill low eight bits, upper 24 bits zero.
// - Halfword zero loads fill low 16 bits, upper 16 zero.
// - Word loads write the whole fetched word unchanged.
// - Halfword algebraic loads copy operand sign into upper 16 bits.
// - Non-update displacement address is displacement plus base or zero.
// - Update displacement address is base plus displacement, written to base.
// - Non-update indexed address is index plus base or zero.
// - Update indexed address is base plus index, written back to base.
// - Displacement is sign-extended from 16 to 32 bits before adding.
// - Base field zero on non-update forms means constant zero.
module ilu_load_unit
    import ilu_pkg::*;
#(
    parameter int XLEN = ILU_XLEN
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Issue from the pipeline
    input  wire logic        issue_valid_in,
    input  wire ilu_op_t     issue_op_in,
    output logic             issue_ready_out,
    // Memory request and answer
    output logic             mem_req_out,
    output logic [XLEN-1:0]  mem_addr_out,
    output ilu_size_t        mem_size_out,
    input  wire logic        mem_ack_in,
    input  wire logic [XLEN-1:0] mem_data_in,
    // Completion
    output logic             done_out,
    output ilu_wr_t          dest_wr_out,
    output ilu_wr_t          base_wr_out,
    output logic             invalid_form_out,
    // Register inspection for the pipeline and tests
    input  wire logic [4:0]  peek_idx_in,
    output logic [XLEN-1:0]  peek_data_out
);

    // Only the 32-bit datapath is built; other widths are refused
    initial begin
        if (XLEN != ILU_XLEN) begin
            $error("ilu_load_unit: only a 32-bit datapath is served");
        end
    end

    typedef enum logic [1:0] {
        ILU_ST_IDLE = 2'b00,
        ILU_ST_READ = 2'b01,
        ILU_ST_MEM  = 2'b10,
        ILU_ST_DONE = 2'b11
    } ilu_state_t;

    ilu_state_t state;
    ilu_state_t next_state;
    ilu_op_t    op;
    logic [XLEN-1:0] eff_addr;
    logic [XLEN-1:0] load_data;
    logic            take;

    // A load is taken only while ready shows, so an offer in the cycle
    // right after reset, when ready is still low, is left waiting
    assign take = (state == ILU_ST_IDLE) && issue_valid_in && issue_ready_out;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Extends a loaded operand to the register width
    // Byte loads honour the algebraic flag too, sign-extending the byte
    function automatic logic [31:0] ilu_extend(input logic [31:0] raw,
                                               input ilu_size_t sz,
                                               input logic alg);
        logic [31:0] r;
        r = raw;
        case (sz)
            ILU_SZ_BYTE: r = alg ? {{24{raw[7]}}, raw[7:0]}
                                 : {24'h00_0000, raw[7:0]};
            ILU_SZ_HALF: r = alg ? {{16{raw[15]}}, raw[15:0]}
                                 : {16'h0000, raw[15:0]};
            ILU_SZ_WORD: r = raw;
            default:     r = raw;
        endcase
        return r;
    endfunction : ilu_extend

    ////////////////////////////////////////////////////////////////////////
    // Register file: base on port a, index on port b
    logic [XLEN-1:0] base_val;
    logic [XLEN-1:0] index_val;
    logic [XLEN-1:0] peek_val;
    logic [4:0]      rd_a_idx;
    logic            fin;

    assign fin      = (state == ILU_ST_DONE);
    // Port a serves the base only on the take edge; at every other edge it
    // reads the inspected register, so a peek works whenever no load starts
    assign rd_a_idx = take ? issue_op_in.base : peek_idx_in;

    ilu_regfile #(
        .DEPTH (ILU_REG_COUNT),
        .WIDTH (XLEN)
    ) u_regs (
        .clock_in    (clock_in),
        .rst_n_in    (rst_n_in),
        .wa_en_in    (fin),
        .wa_idx_in   (op.dest),
        .wa_data_in  (load_data),
        .wb_en_in    (fin && op.update),
        .wb_idx_in   (op.base),
        .wb_data_in  (eff_addr),
        .ra_idx_in   (rd_a_idx),
        .rb_idx_in   (issue_op_in.index),
        .ra_data_out (base_val),
        .rb_data_out (index_val)
    );
    // Inspection data comes from port a one cycle after the index
    assign peek_val = base_val;

    ////////////////////////////////////////////////////////////////////////
    // Address arithmetic
    logic            base_is_zero;
    logic [XLEN-1:0] base_term;
    logic [XLEN-1:0] disp_ext;
    logic [XLEN-1:0] offset_term;
    logic [XLEN-1:0] next_eff_addr;
    logic            next_invalid;

    assign base_is_zero = (op.base == ILU_REG_ZERO);
    // Update forms always read the register, even r0, so a bad form
    // still produces a bounded address instead of trapping.
    assign base_term = (base_is_zero && !op.update) ? ILU_RST_WORD
                                                    : base_val;
    // Displacement keeps its sign so negative offsets step backwards
    assign disp_ext = {{(XLEN-ILU_DISP_W){op.disp[15]}}, op.disp};
    assign offset_term = (op.amode == ILU_AM_INDEX) ? index_val
                                                    : disp_ext;
    // Carry out of bit 31 is dropped by the width of the sum
    assign next_eff_addr = XLEN'(base_term + offset_term);
    // Flagged only for visibility; the load still completes
    assign next_invalid = op.update &&
                          (base_is_zero || op.base == op.dest);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    // The memory wait has no limit of its own; a lost acknowledge stalls
    // the unit, and any timeout belongs to the pipeline around it
    always_comb begin
        next_state = state;
        case (state)
            ILU_ST_IDLE: if (take) next_state = ILU_ST_READ;
            ILU_ST_READ: next_state = ILU_ST_MEM;
            ILU_ST_MEM:  if (mem_ack_in) next_state = ILU_ST_DONE;
            ILU_ST_DONE: next_state = ILU_ST_IDLE;
            default:     next_state = ILU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state <= ILU_ST_IDLE;
            op    <= '0;
        end else begin
            state <= next_state;
            if (take) begin
                op <= issue_op_in;
            end
        end
    end

    // Address and memory request
    // Address and size then stand unchanged until the acknowledge edge
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            eff_addr         <= ILU_RST_WORD;
            mem_req_out      <= 1'b0;
            mem_addr_out     <= ILU_RST_WORD;
            mem_size_out     <= ILU_SZ_BYTE;
            invalid_form_out <= 1'b0;
            load_data        <= ILU_RST_WORD;
        end else begin
            if (state == ILU_ST_READ) begin
                eff_addr         <= next_eff_addr;
                mem_addr_out     <= next_eff_addr;
                mem_size_out     <= op.size;
                mem_req_out      <= 1'b1;
                invalid_form_out <= next_invalid;
            end
            if (state == ILU_ST_MEM && mem_ack_in) begin
                mem_req_out <= 1'b0;
                load_data   <= ilu_extend(mem_data_in, op.size, op.algebraic);
            end
        end
    end

    // Completion outputs as one-cycle pulses, plus the ready level and inspection data
    // Write ports mirror what the register file takes at the same edge,
    // so the pipeline can forward without reading the file back
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            done_out        <= 1'b0;
            dest_wr_out     <= '0;
            base_wr_out     <= '0;
            issue_ready_out <= 1'b0;
            peek_data_out   <= ILU_RST_WORD;
        end else begin
            done_out        <= fin;
            dest_wr_out     <= '{en: fin, idx: op.dest, data: load_data};
            base_wr_out     <= '{en: fin && op.update, idx: op.base,
                                 data: eff_addr};
            issue_ready_out <= (next_state == ILU_ST_IDLE);
            peek_data_out   <= peek_val;
        end
    end

endmodule : ilu_load_unit

// ### verification/ilu_load_unit_sva.sv
`timescale 1ns/1ps
module ilu_load_unit_sva
    import ilu_pkg::*;
#(
    parameter int XLEN = ILU_XLEN
) (
    // Clock and reset
    input wire logic            clock_in,
    input wire logic            rst_n_in,
    // Issue and memory
    input wire logic            issue_valid_in,
    input wire ilu_op_t         issue_op_in,
    input wire logic            issue_ready_out,
    input wire logic            mem_req_out,
    input wire logic [XLEN-1:0] mem_addr_out,
    input wire ilu_size_t       mem_size_out,
    input wire logic            mem_ack_in,
    input wire logic [XLEN-1:0] mem_data_in,
    // Completion
    input wire logic            done_out,
    input wire ilu_wr_t         dest_wr_out,
    input wire ilu_wr_t         base_wr_out,
    input wire logic            invalid_form_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////
    ilu_op_t         op_q;
    logic [XLEN-1:0] dat_q;
    wire take = issue_valid_in && issue_ready_out;
    wire ack  = mem_req_out && mem_ack_in;
    // Keep the load and its data, since the register file is out of sight
    always_ff @(posedge clock_in) begin
        if (take) op_q <= issue_op_in;
        if (ack) dat_q <= mem_data_in;
    end
    // Expected result and form checks
    wire [31:0] ext = (op_q.size == ILU_SZ_BYTE)
        ? {{24{op_q.algebraic & dat_q[7]}}, dat_q[7:0]}
        : (op_q.size == ILU_SZ_HALF)
        ? {{16{op_q.algebraic & dat_q[15]}}, dat_q[15:0]} : dat_q[31:0];
    wire bad = op_q.update && (op_q.base == 5'h00 || op_q.base == op_q.dest);
    wire zb = !op_q.update && op_q.base == 5'h00 && op_q.amode == ILU_AM_DISP;
    ////////////////////////////////////////////////////////////////////////
    req_after_take_a: assert property (take |-> ##2 mem_req_out)
        else $error("request late");
    req_hold_a: assert property (mem_req_out && !mem_ack_in |=>
        mem_req_out && $stable(mem_addr_out) && $stable(mem_size_out))
        else $error("request dropped");
    zero_base_a: assert property (mem_req_out && zb |->
        mem_addr_out == {{16{op_q.disp[15]}}, op_q.disp})
        else $error("zero base address");
    done_pulse_a: assert property (ack |-> ##2 done_out ##1 !done_out)
        else $error("done timing");
    ext_data_a: assert property (dest_wr_out.en |->
        dest_wr_out.data == ext && dest_wr_out.idx == op_q.dest)
        else $error("dest data");
    base_en_a: assert property (done_out |-> base_wr_out.en == op_q.update)
        else $error("base enable");
    base_data_a: assert property (base_wr_out.en |->
        base_wr_out.data == $past(mem_addr_out, 2) &&
        base_wr_out.idx == op_q.base) else $error("base data");
    invalid_a: assert property (done_out |-> invalid_form_out == bad)
        else $error("form flag");
    cover property (base_wr_out.en && invalid_form_out);
    cover property (mem_req_out && !mem_ack_in ##1 mem_ack_in);
    cover property (dest_wr_out.en && dest_wr_out.data[31]);
endmodule : ilu_load_unit_sva

// ### verification/ilu_mem_model.sv
`timescale 1ns/1ps
module ilu_mem_model (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Request in, answer out
    input  wire logic        mem_req_in,
    input  wire logic [3:0]  delay_in,
    input  wire logic [31:0] word_in,
    output logic             ack_out,
    output logic [31:0]      data_out
);
    logic [3:0] cnt;
    // Answer delay_in+1 cycles after the request rises; data toggles otherwise so stale use shows
    always @(posedge clock_in) begin
        ack_out <= 1'b0;
        data_out <= ~data_out;
        if (!rst_n_in) begin
            cnt <= 4'h0;
            data_out <= 32'h0;
        end else if (mem_req_in && !ack_out) begin
            cnt <= (cnt == delay_in) ? 4'h0 : cnt + 4'h1;
            ack_out <= (cnt == delay_in);
            if (cnt == delay_in) data_out <= word_in;
        end
    end
endmodule : ilu_mem_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import ilu_pkg::*;
;
    // Wiring, shadow registers and score
    logic        clock_in = 1'b0;
    logic        rst_n_in, issue_valid_in, issue_ready_out, mem_req_out;
    logic        mem_ack_in, done_out, invalid_form_out;
    logic [31:0] mem_addr_out, mem_data_in, peek_data_out, mem_word;
    logic [4:0]  peek_idx_in;
    logic [3:0]  mem_dly;
    ilu_op_t     issue_op_in;
    ilu_size_t   mem_size_out;
    ilu_wr_t     dest_wr_out, base_wr_out;
    logic [31:0] regs [32];
    int          n_fail = 0;
    int          num_checks = 0;
    localparam ilu_size_t  zb = ILU_SZ_BYTE, zh = ILU_SZ_HALF, zw = ILU_SZ_WORD;
    localparam ilu_amode_t ad = ILU_AM_DISP, ax = ILU_AM_INDEX;

    always #12.5 clock_in = ~clock_in;
    ilu_load_unit u_ilu_load_unit (.clock_in, .rst_n_in, .issue_valid_in,
        .issue_op_in, .issue_ready_out, .mem_req_out, .mem_addr_out,
        .mem_size_out, .mem_ack_in, .mem_data_in, .done_out, .dest_wr_out,
        .base_wr_out, .invalid_form_out, .peek_idx_in, .peek_data_out);
    ilu_mem_model u_ilu_mem_model (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .mem_req_in(mem_req_out), .delay_in(mem_dly), .word_in(mem_word),
        .ack_out(mem_ack_in), .data_out(mem_data_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Bounded wait of 40 negedges, so a stuck handshake returns as a miss, not a hang
    // Selector: 0 ready, 1 request, 2 done; running out counts as a miss
    task automatic wait_hi(input int sel);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 40 && !hit; n++) begin
            hit = (sel == 0) ? (issue_ready_out === 1'b1)
                : (sel == 1) ? (mem_req_out === 1'b1) : (done_out === 1'b1);
            if (!hit) @(negedge clock_in);
        end
        if (!hit) n_fail++;
    endtask : wait_hi
    // One load; au is {algebraic, update}; peeks base on update forms
    task automatic ld(input ilu_size_t sz, input int au, input ilu_amode_t am,
            input int dst, input int b, input int x, input logic [15:0] dsp,
            input logic [31:0] d, input int dly);
        logic [31:0] ea;
        logic [31:0] ex;
        ea = ((b == 0 && au[0] == 1'b0) ? 32'h0 : regs[b])
            + ((am == ax) ? regs[x] : {{16{dsp[15]}}, dsp});
        ex = (sz == zb) ? {{24{au[1] & d[7]}}, d[7:0]}
            : (sz == zh) ? {{16{au[1] & d[15]}}, d[15:0]} : d;
        mem_dly = 4'(dly);
        mem_word = d;
        issue_op_in = '{sz, au[1], au[0], am, 5'(dst), 5'(b), 5'(x), dsp};
        issue_valid_in = 1'b1;
        wait_hi(0);
        @(negedge clock_in);
        issue_valid_in = 1'b0;
        wait_hi(1);
        check(mem_addr_out, ea);
        check(32'(mem_size_out), 32'(sz));
        wait_hi(2);
        check(dest_wr_out.data, ex);
        check(32'(dest_wr_out.idx), 32'(dst));
        check(32'(invalid_form_out), 32'(au[0] && (b == 0 || b == dst)));
        check(32'(base_wr_out.en), 32'(au[0]));
        if (au[0]) check(base_wr_out.data, ea);
        regs[dst] = ex;
        if (au[0]) regs[b] = ea;
        peek_idx_in = 5'(au[0] ? b : dst);
        repeat (2) @(negedge clock_in);
        check(peek_data_out, regs[peek_idx_in]);
    endtask : ld
    ////////////////////////////////////////////////////////////////////////
    task automatic t_fill();
        ld(zw, 0, ad, 0, 0, 0, 16'h0100, 32'h5555aaaa, 0);
        ld(zw, 0, ad, 1, 0, 0, 16'h0104, 32'h00002000, 2);
        ld(zw, 0, ad, 2, 0, 0, 16'h0108, 32'hfffffff0, 5);
        ld(zw, 0, ad, 3, 0, 0, 16'h010c, 32'h00000010, 1);
    endtask : t_fill
    task automatic t_extend();
        ld(zb, 0, ad, 4, 0, 0, 16'h8000, 32'h123456a5, 0);
        ld(zh, 2, ad, 5, 1, 0, 16'hfffe, 32'habcd8001, 3);
        ld(zh, 0, ax, 6, 1, 3, 16'h0000, 32'hffff9876, 0);
        ld(zw, 0, ax, 11, 0, 3, 16'h0000, 32'h01020304, 1);
        ld(zb, 2, ax, 13, 3, 1, 16'h0000, 32'h000000c3, 4);
    endtask : t_extend
    // Legal update forms: base nonzero and unlike the destination
    task automatic t_update();
        ld(zh, 3, ad, 7, 1, 0, 16'hfff0, 32'h12347fff, 2);
        ld(zw, 1, ax, 8, 2, 3, 16'h0000, 32'hcafef00d, 0);
    endtask : t_update
    // Illegal update forms still finish; a clean load follows at once
    task automatic t_invalid();
        ld(zw, 1, ad, 9, 9, 0, 16'h0008, 32'h0badf00d, 1);
        ld(zb, 1, ad, 10, 0, 0, 16'h0004, 32'h000000ff, 0);
        ld(zb, 0, ad, 12, 1, 0, 16'h0001, 32'hffffff80, 0);
    endtask : t_invalid
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_in = 1'b0;
        issue_valid_in = 1'b0;
        issue_op_in = '0;
        peek_idx_in = 5'h00;
        mem_word = 32'h0;
        foreach (regs[i]) regs[i] = 32'h0;
        repeat (6) @(negedge clock_in);
        rst_n_in = 1'b1;
        @(negedge clock_in);
        t_fill();
        t_extend();
        t_update();
        t_invalid();
        tally_and_finish();
    end
    // Watchdog, well past the 120-odd cycles the loads need
    initial begin
        repeat (4000) @(posedge clock_in);
        n_fail++;
        tally_and_finish();
    end
endmodule : tb_top
bind ilu_load_unit ilu_load_unit_sva #(.XLEN(XLEN)) u_ilu_load_unit_sva (
    .clock_in, .rst_n_in, .issue_valid_in, .issue_op_in, .issue_ready_out,
    .mem_req_out, .mem_addr_out, .mem_size_out, .mem_ack_in, .mem_data_in,
    .done_out, .dest_wr_out, .base_wr_out, .invalid_form_out);
